// >>> verif/tdm_line_model.sv
/*
 * Line transformer and cable seen from the monitor pins.
 * Assumes monitor pins are wired back to the driven pair.
 */
`timescale 1ns/1ps
`default_nettype none
module tdm_line_model (
    input wire logic i_sys_clk,
    input wire logic i_line_tip,
    input wire logic i_line_ring,
    input wire logic i_line_oe,
    input wire logic i_noise,
    output logic o_mon_tip,
    output logic o_mon_ring
);
    // noise swings every four clocks so it clears the pin filter
    logic [2:0] slow = 3'h0;
    logic flip;
    always @(posedge i_sys_clk) begin
        slow <= slow + 3'h1;
    end
    assign flip = slow[2];
    // released pair floats together, no bipolar swing
    assign o_mon_tip = (i_noise | ~i_line_oe) ? flip : i_line_tip;
    assign o_mon_ring = i_noise ? ~flip : (i_line_oe ? i_line_ring : flip);
endmodule
`default_nettype wire

// >>> verif/testbench.sv
/*
 * Self-checking bench for the transmit driver and drive monitor.
 * Assumes the line model loops the pair back to the monitor pins.
 */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import tdm_pkg::*;
    logic clk = 1'h0, rst = 1'h1, ben = 1'h0, pos = 1'h0;
    logic neg = 1'h0, en = 1'h0, intl = 1'h1, noise = 1'h0;
    logic psh = 1'h0, ben_d = 1'h0;
    wire logic mt, mr, tip, ring, oe, flt;
    int bad_count = 0, compares = 0;
    logic [31:0] lfsr = 32'h1DD19A24;
    logic [1:0] q[$];
    tdm_transmit_drive_monitor tdm_transmit_drive_monitor_inst (
        .i_sys_clk(clk), .i_rst(rst), .i_bit_en(ben), .i_tx_pos(pos),
        .i_tx_neg(neg), .i_transmitter_output_enable(en),
        .i_monitor_internal(intl), .i_monitor_in_tip(mt),
        .i_monitor_in_ring(mr), .o_line_out_tip(tip),
        .o_line_out_ring(ring), .o_line_out_oe(oe), .o_drive_fault_out(flt));
    tdm_line_model tdm_line_model_inst (.i_sys_clk(clk), .i_line_tip(tip),
        .i_line_ring(ring), .i_line_oe(oe), .i_noise(noise),
        .o_mon_tip(mt), .o_mon_ring(mr));
    initial begin
        forever #4 clk = ~clk;
    end
    task automatic check(input logic [2:0] seen, input logic [2:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: seen %0h expected %0h", $time,
                seen, exp);
        end
    endtask
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // mode 0 zeros, 1 random symbols, 2 one positive pulse each bit
    task automatic bits(input int n, input int mode);
        logic p, m;
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            lfsr = lfsr_next(lfsr);
            p = (mode == 2) || (mode == 1 && lfsr[0]);
            m = (mode == 1) && lfsr[1];
            ben <= 1;
            pos <= p;
            neg <= m;
            psh <= (mode != 0);
            if (mode != 0) q.push_back({p & ~m, m & ~p});
        end
        @(posedge clk);
        ben <= 0;
        psh <= 0;
        repeat (2) @(posedge clk);
    endtask
    always @(posedge clk) begin
        ben_d <= ben & psh;
        if (ben_d) check({1'h0, tip, ring}, {1'h0, q.pop_front()});
    end
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst <= 0;
        en <= 1;
        repeat (8) @(posedge clk);
        bits(64, 1);
        $display("symbol test done");
        bits(1, 2);
        bits(124, 0);
        check({2'h0, flt}, 3'h0);
        bits(8, 0);
        check({2'h0, flt}, 3'h1);
        bits(1, 2);
        check({2'h0, flt}, 3'h0);
        $display("silence test done");
        intl <= 0;
        noise <= 1;
        bits(200, 0);
        check({2'h0, flt}, 3'h0);
        intl <= 1;
        bits(200, 0);
        check({2'h0, flt}, 3'h1);
        noise <= 0;
        $display("monitor source test done");
        en <= 0;
        repeat (8) @(posedge clk);
        check({oe, tip, ring}, 3'h0);
        en <= 1;
        intl <= 0;
        repeat (8) @(posedge clk);
        check({oe, tip, ring}, 3'h4);
        bits(1, 2);
        bits(4, 0);
        check({2'h0, flt}, 3'h0);
        $display("enable test done");
        final_report();
    end
    initial begin
        repeat (5000) @(posedge clk);
        bad_count++;
        final_report();
    end
endmodule
`default_nettype wire

// >>> verilog/tdm_pkg.sv
/*
 * Constants for one channel's transmit line driver and drive monitor:
 * silence limit, counter width and reset values.
 * Assumes a single system clock; the bit period arrives as an enable pulse.
 */
// Notes on behaviour
// - positive pulse: tip above ring
// - negative pulse: tip below ring
// - enable zero: tip and ring high impedance
// - fault high after 128 silent bit periods
// - fault low after pulse within 128 periods
// - internal monitoring ignores external monitor inputs
`default_nettype none
package tdm_pkg;
    localparam int TDM_CNT_W = 8;
    // bit periods of silence before the fault is raised
    localparam logic [TDM_CNT_W-1:0] TDM_SILENT_LIMIT = 8'h80;
    localparam logic [TDM_CNT_W-1:0] TDM_CNT_RST = 8'h00;
    localparam logic [TDM_CNT_W-1:0] TDM_CNT_ONE = 8'h01;
    localparam logic TDM_FAULT_RST = 1'h0;
    localparam logic TDM_OE_RST = 1'h0;
    localparam logic TDM_LINE_RST = 1'h0;
    localparam logic [2:0] TDM_SYNC_RST = 3'h0;
endpackage
`default_nettype wire

// >>> verilog/tdm_transmit_drive_monitor.sv
/*
 * One channel transmit line driver and transmit drive monitor.
 * Drives tip/ring levels from dual-rail pulses, tri-states the pair
 * while the transmitter output enable is low, and raises the drive
 * fault output after a run of bit periods with no bipolar activity.
 * Assumes i_bit_en pulses once per line bit period on i_sys_clk, and
 * that i_tx_pos, i_tx_neg and i_monitor_internal come from logic on the
 * same clock. Enable and monitor pins are asynchronous.
 */
`timescale 1ns/1ps
`default_nettype none
module tdm_transmit_drive_monitor
    import tdm_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_bit_en,
    input wire logic i_tx_pos,
    input wire logic i_tx_neg,
    input wire logic i_transmitter_output_enable,
    input wire logic i_monitor_internal,
    input wire logic i_monitor_in_tip,
    input wire logic i_monitor_in_ring,
    output logic o_line_out_tip,
    output logic o_line_out_ring,
    output logic o_line_out_oe,
    output logic o_drive_fault_out
);

    // pin synchronisers, index 0 is the first stage
    logic [2:0] en_sync;
    logic [2:0] mtip_sync;
    logic [2:0] mring_sync;
    logic [2:0] next_en_sync;
    logic [2:0] next_mtip_sync;
    logic [2:0] next_mring_sync;

    // settled copies of the external monitor pins
    logic ext_tip;
    logic ext_ring;
    logic next_ext_tip;
    logic next_ext_ring;

    // line driver state
    logic next_oe;
    logic next_tip;
    logic next_ring;

    // monitor state
    logic [TDM_CNT_W-1:0] silent_cnt;
    logic [TDM_CNT_W-1:0] next_silent_cnt;
    logic next_fault;
    logic int_activity;
    logic ext_activity;
    logic activity;

    // ---------------- input synchronisers ----------------
    always_comb begin
        next_en_sync = {en_sync[1:0], i_transmitter_output_enable};
        next_mtip_sync = {mtip_sync[1:0], i_monitor_in_tip};
        next_mring_sync = {mring_sync[1:0], i_monitor_in_ring};
        next_ext_tip = ext_tip;
        next_ext_ring = ext_ring;
        // a change counts once stages two and three agree
        if (mtip_sync[1] == mtip_sync[2]) begin
            next_ext_tip = mtip_sync[2];
        end
        if (mring_sync[1] == mring_sync[2]) begin
            next_ext_ring = mring_sync[2];
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            en_sync <= TDM_SYNC_RST;
            mtip_sync <= TDM_SYNC_RST;
            mring_sync <= TDM_SYNC_RST;
            ext_tip <= TDM_LINE_RST;
            ext_ring <= TDM_LINE_RST;
        end else begin
            en_sync <= next_en_sync;
            mtip_sync <= next_mtip_sync;
            mring_sync <= next_mring_sync;
            ext_tip <= next_ext_tip;
            ext_ring <= next_ext_ring;
        end
    end

    // ---------------- line driver ----------------
    always_comb begin
        next_oe = o_line_out_oe;
        if (en_sync[1] == en_sync[2]) begin
            next_oe = en_sync[2];
        end
        next_tip = o_line_out_tip;
        next_ring = o_line_out_ring;
        if (!next_oe) begin
            // pair released to high impedance, levels parked low
            next_tip = 1'h0;
            next_ring = 1'h0;
        end else if (i_bit_en) begin
            // both rails at once is not a legal symbol: send a zero
            next_tip = i_tx_pos && !i_tx_neg;
            next_ring = i_tx_neg && !i_tx_pos;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_line_out_oe <= TDM_OE_RST;
            o_line_out_tip <= TDM_LINE_RST;
            o_line_out_ring <= TDM_LINE_RST;
        end else begin
            o_line_out_oe <= next_oe;
            o_line_out_tip <= next_tip;
            o_line_out_ring <= next_ring;
        end
    end

    // ---------------- drive monitor ----------------
    always_comb begin
        // bipolar activity: the pair differs, either polarity
        int_activity = o_line_out_oe && (o_line_out_tip != o_line_out_ring);
        ext_activity = ext_tip != ext_ring;
        // external pins play no part under internal monitoring
        activity = i_monitor_internal ? int_activity
                                      : ext_activity;
        next_silent_cnt = silent_cnt;
        if (activity) begin
            next_silent_cnt = TDM_CNT_RST;
        end else if (i_bit_en && silent_cnt != TDM_SILENT_LIMIT) begin
            next_silent_cnt = silent_cnt + TDM_CNT_ONE;
        end
        next_fault = (next_silent_cnt == TDM_SILENT_LIMIT);
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            silent_cnt <= TDM_CNT_RST;
            o_drive_fault_out <= TDM_FAULT_RST;
        end else begin
            silent_cnt <= next_silent_cnt;
            o_drive_fault_out <= next_fault;
        end
    end

    // ---------------- checks ----------------
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_rst);

    a_pos_drive: assert property (
        i_bit_en && i_tx_pos && !i_tx_neg && next_oe
        |=> o_line_out_tip && !o_line_out_ring && o_line_out_oe)
        else $error("positive pulse not driven tip high");

    a_neg_drive: assert property (
        i_bit_en && i_tx_neg && !i_tx_pos && next_oe
        |=> !o_line_out_tip && o_line_out_ring && o_line_out_oe)
        else $error("negative pulse not driven ring high");

    a_off_released: assert property (
        (en_sync[1] == en_sync[2]) && !en_sync[2]
        |=> !o_line_out_oe && !o_line_out_tip && !o_line_out_ring)
        else $error("line pair not released while disabled");

    a_on_follows: assert property (
        $rose(en_sync[2]) && en_sync[1] |=> o_line_out_oe)
        else $error("line enable did not follow settled pin");

    a_fault_rise: assert property (
        i_bit_en && !activity && silent_cnt == TDM_SILENT_LIMIT - TDM_CNT_ONE
        |=> o_drive_fault_out && silent_cnt == TDM_SILENT_LIMIT)
        else $error("fault not raised after silent limit");

    a_fault_early: assert property (
        silent_cnt < TDM_SILENT_LIMIT - TDM_CNT_ONE |=> !o_drive_fault_out)
        else $error("fault raised before silent limit");

    a_fault_clear: assert property (
        activity |=> !o_drive_fault_out && silent_cnt == TDM_CNT_RST
        ##1 !o_drive_fault_out)
        else $error("fault not cleared by a pulse");

    a_ext_ignored: assert property (
        i_monitor_internal && !int_activity && i_bit_en
        && silent_cnt != TDM_SILENT_LIMIT
        |=> silent_cnt == $past(silent_cnt) + TDM_CNT_ONE)
        else $error("external pins reached internal monitor");

    a_count_hold: assert property (
        !i_bit_en && !activity |=> $stable(silent_cnt))
        else $error("silence count moved without a bit period");

    a_count_sat: assert property (
        silent_cnt == TDM_SILENT_LIMIT && !activity
        |=> silent_cnt == TDM_SILENT_LIMIT && o_drive_fault_out)
        else $error("silence count left its limit");

    a_both_rails: assert property (
        i_bit_en && i_tx_pos && i_tx_neg && next_oe
        |=> !o_line_out_tip && !o_line_out_ring)
        else $error("both rails did not send a zero");

    // a symbol stands for its whole bit period
    a_symbol_hold: assert property (
        !i_bit_en && next_oe
        |=> $stable(o_line_out_tip) && $stable(o_line_out_ring))
        else $error("line level moved inside a bit period");

    a_ext_used: assert property (
        !i_monitor_internal && ext_activity |=> silent_cnt == TDM_CNT_RST)
        else $error("external activity did not restart count");

    a_int_quiet: assert property (
        i_monitor_internal && !o_line_out_oe |-> !activity)
        else $error("released pair seen as activity");

    c_pos_pulse: cover property (
        i_bit_en && i_tx_pos && next_oe ##1 o_line_out_tip);
    c_fault_set: cover property ($rose(o_drive_fault_out));
    c_fault_cleared: cover property ($fell(o_drive_fault_out));
    c_ext_monitor: cover property (!i_monitor_internal && ext_activity);
    c_line_released: cover property ($fell(o_line_out_oe));

endmodule
`default_nettype wire
